// ===== rtl/uts_uart_tx_status_control.sv
// Summary of operation
// - Transmit interrupt select field at bits 15,13; 10 fires when buffer empties; 11 reserved.
// - Infrared off: polarity invert makes line idle low, else idle high.
// - Infrared on: polarity invert makes encoded output idle high.
// - Send-break makes next frame start bit, twelve zeros, stop bit.
// - Hardware clears send-break once the break frame completes.
// - Clearing transmit enable aborts, flushes buffer, hands pin to port logic.
// - Shift-empty reads 1 only when shifter and buffer empty; resets to 1.
// - Receive interrupt select bits 7-6: 11 full, 10 three chars, 0x every char.
//
// Our own choices: register access over Avalon-MM and the register offsets.
module uts_uart_tx_status_control (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [2:0] rx_count_i,
  input wire logic rx_char_i,
  output logic tx_line_o,
  output logic tx_line_oe_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  localparam int TX_DEPTH = uts_pkg::TX_DEPTH;
  logic [15:0] ctrl;
  logic [15:0] baud_div;
  logic [7:0] fifo [TX_DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] count;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  uts_pkg::uts_state_t state;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [15:0] baud_cnt;
  logic is_break;
  logic line_bit;
  logic ack_q;

  // One-cycle wait then answer with clk_en_i high: request taken on second enabled edge
  wire access = avs_read_i | avs_write_i;
  wire take = access & ack_q & clk_en_i;
  wire wr_take = take & avs_write_i & ~avs_read_i;
  wire tx_en = ctrl[uts_pkg::BIT_TX_EN];
  wire buf_full = (count == 3'(TX_DEPTH));
  wire buf_empty = (count == 3'h0);
  wire shift_empty = buf_empty && (state == uts_pkg::UTS_IDLE);
  wire baud_tick = (baud_cnt == 16'h0000);
  wire push = wr_take && (avs_address_i == uts_pkg::ADDR_TX_DATA) && avs_byteenable_i[0] && !buf_full && tx_en;
  wire load = tx_en && baud_tick && (state == uts_pkg::UTS_IDLE) && (!buf_empty || ctrl[uts_pkg::BIT_BREAK]);
  wire pop = load && !ctrl[uts_pkg::BIT_BREAK];
  wire frame_done = tx_en && baud_tick && (state == uts_pkg::UTS_STOP);
  wire [1:0] tx_sel = {ctrl[uts_pkg::BIT_IRQ_SEL1], ctrl[uts_pkg::BIT_IRQ_SEL0]};
  wire [1:0] rx_sel = {ctrl[uts_pkg::BIT_RX_SEL1], ctrl[uts_pkg::BIT_RX_SEL0]};

  // Merge a 16-bit write under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // Ack alternates so each access sees exactly one wait cycle while clk_en_i stays high; clk_en_i low holds waitrequest
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else if (clk_en_i) begin
      ack_q <= access & ~ack_q;
    end
  end
  assign avs_waitrequest_o = access & ~(ack_q & clk_en_i);

  // Read data registered in the wait cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (clk_en_i && avs_read_i && !ack_q) begin
      case (avs_address_i)
        uts_pkg::ADDR_STATUS_CONTROL: avs_readdata_o <= {16'h0000, ctrl[15:10], buf_full, shift_empty,
          ctrl[7:5], 1'b1, 4'h0};
        uts_pkg::ADDR_BAUD_DIV: avs_readdata_o <= {16'h0000, baud_div};
        uts_pkg::ADDR_IRQ_STATUS: avs_readdata_o <= {29'h0, irq_status};
        uts_pkg::ADDR_IRQ_ENABLE: avs_readdata_o <= {29'h0, irq_enable};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Break bit self-clears at end of the break frame; hardware clear loses to a fresh set
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ctrl <= uts_pkg::CTRL_RESET;
    end else if (clk_en_i) begin
      if (frame_done && is_break) begin
        ctrl[uts_pkg::BIT_BREAK] <= 1'b0;
      end
      if (wr_take && avs_address_i == uts_pkg::ADDR_STATUS_CONTROL) begin
        ctrl <= merge16(ctrl, avs_writedata_i, avs_byteenable_i) & uts_pkg::CTRL_WMASK;
      end
    end
  end

  // Baud divisor, software written
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      baud_div <= uts_pkg::BAUD_DIV_RESET;
    end else if (clk_en_i && wr_take && avs_address_i == uts_pkg::ADDR_BAUD_DIV) begin
      baud_div <= merge16(baud_div, avs_writedata_i, avs_byteenable_i);
    end
  end

  // ---------------------------------------------------------------
  // Transmit buffer
  // ---------------------------------------------------------------
  // Disable flushes the buffer; writes while disabled are dropped
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count <= 3'h0;
    end else if (clk_en_i) begin
      if (!tx_en) begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        count <= 3'h0;
      end else begin
        if (push) begin
          fifo[wr_ptr] <= avs_writedata_i[7:0];
          wr_ptr <= wr_ptr + 2'h1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 2'h1;
        end
        count <= count + 3'(push) - 3'(pop);
      end
    end
  end

  // ---------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------
  // Baud counter runs only while enabled
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      baud_cnt <= 16'h0000;
    end else if (clk_en_i) begin
      if (!tx_en || baud_tick) begin
        baud_cnt <= baud_div;
      end else begin
        baud_cnt <= baud_cnt - 16'h0001;
      end
    end
  end

  // Frame sequencer; break frame carries twelve zeros in place of data
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= uts_pkg::UTS_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      is_break <= 1'b0;
    end else if (clk_en_i) begin
      if (!tx_en) begin
        state <= uts_pkg::UTS_IDLE;
      end else if (baud_tick) begin
        case (state)
          uts_pkg::UTS_IDLE: if (load) begin
            state <= uts_pkg::UTS_START;
            is_break <= ctrl[uts_pkg::BIT_BREAK];
            shreg <= ctrl[uts_pkg::BIT_BREAK] ? 8'h00 : fifo[rd_ptr];
          end
          uts_pkg::UTS_START: begin
            state <= uts_pkg::UTS_DATA;
            bit_cnt <= (is_break ? uts_pkg::BREAK_BITS : uts_pkg::DATA_BITS) - 4'h1;
          end
          uts_pkg::UTS_DATA: begin
            shreg <= {1'b0, shreg[7:1]};
            if (bit_cnt == 4'h0) begin
              state <= uts_pkg::UTS_STOP;
            end else begin
              bit_cnt <= bit_cnt - 4'h1;
            end
          end
          uts_pkg::UTS_STOP: state <= uts_pkg::UTS_IDLE;
          default: state <= uts_pkg::UTS_IDLE;
        endcase
      end
    end
  end

  // Line level: logic 1 is idle/stop, before polarity
  always_comb begin
    case (state)
      uts_pkg::UTS_START: line_bit = 1'b0;
      uts_pkg::UTS_DATA: line_bit = shreg[0];
      default: line_bit = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // Line output
  // ---------------------------------------------------------------
  // Infrared: zero bits pulse in first part of the bit; idle level follows invert bit
  // Limitation: pulse lasts while the baud counter low bits exceed IR_PULSE_DIV, so it is not a fixed fraction of the bit
  wire ir_pulse = (baud_cnt[3:0] > uts_pkg::IR_PULSE_DIV);
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_line_o <= 1'b1;
      tx_line_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      tx_line_oe_o <= tx_en;
      if (ctrl[uts_pkg::BIT_IR_EN]) begin
        tx_line_o <= (!line_bit && ir_pulse) ^ ctrl[uts_pkg::BIT_POL_INV];
      end else begin
        tx_line_o <= line_bit ^ ctrl[uts_pkg::BIT_POL_INV];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic tx_event;
  always_comb begin
    case (tx_sel)
      uts_pkg::TXSEL_BUF_EMPTY: tx_event = pop && count == 3'h1;
      uts_pkg::TXSEL_ALL_DONE: tx_event = frame_done && buf_empty && !is_break;
      uts_pkg::TXSEL_CHAR_IN: tx_event = pop;
      default: tx_event = 1'b0;
    endcase
  end
  logic rx_event;
  always_comb begin
    case (rx_sel)
      2'b11: rx_event = rx_char_i && rx_count_i == 3'h4;
      2'b10: rx_event = rx_char_i && rx_count_i == 3'h3;
      default: rx_event = rx_char_i;
    endcase
  end
  wire [2:0] events = {rx_event, frame_done && is_break, tx_event};
  wire [2:0] clr = (wr_take && avs_address_i == uts_pkg::ADDR_IRQ_CLEAR) ? avs_writedata_i[2:0] : 3'h0;
  // Set beats clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      irq_status <= uts_pkg::IRQ_RESET;
      irq_enable <= uts_pkg::IRQ_RESET;
    end else if (clk_en_i) begin
      irq_status <= (irq_status & ~clr) | events;
      if (wr_take && avs_address_i == uts_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable <= avs_writedata_i[2:0];
      end
    end
  end
  assign irq_o = |(irq_status & irq_enable);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Buffer never counts past its depth, so the full flag cannot be skipped
  a_full_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
    count <= 3'h4) else $error("buffer overfilled");
  a_empty_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && push) |=> !shift_empty) else $error("shift empty set while queued");
  a_reset_empty: assert property (@(posedge clock_i)
    $rose(resetn_i) |-> shift_empty) else $error("shift empty not set at reset");
  a_break_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && frame_done && is_break && !wr_take) |=> !ctrl[uts_pkg::BIT_BREAK]) else $error("break kept");
  a_break_zeros: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && baud_tick && state == uts_pkg::UTS_START && is_break && tx_en) |=> bit_cnt == 4'hB)
    else $error("break length wrong");
  a_disable_flush: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && !tx_en) |=> (count == 3'h0 && state == uts_pkg::UTS_IDLE)) else $error("abort failed");
  a_idle_level: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && state == uts_pkg::UTS_IDLE && !ctrl[uts_pkg::BIT_IR_EN]) |=> tx_line_o == !$past(ctrl[14]))
    else $error("idle level wrong");
  a_ir_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && state == uts_pkg::UTS_IDLE && ctrl[uts_pkg::BIT_IR_EN]) |=> tx_line_o == $past(ctrl[14]))
    else $error("encoded idle wrong");
  a_reserved_sel: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && tx_sel == uts_pkg::TXSEL_RESERVED && !irq_status[uts_pkg::IRQ_TX]) |=> !irq_status[uts_pkg::IRQ_TX])
    else $error("reserved select fired");
  a_rx_full: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (rx_sel == 2'b11 && rx_char_i && rx_count_i != 3'h4) |-> !rx_event) else $error("rx select wrong");
  a_tx_drive: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clk_en_i && tx_en) |=> tx_line_oe_o) else $error("line not driven");
  c_break: cover property (@(posedge clock_i) frame_done && is_break);
  c_full: cover property (@(posedge clock_i) buf_full);
  c_irq: cover property (@(posedge clock_i) irq_o);
  c_reserved: cover property (@(posedge clock_i) tx_sel == uts_pkg::TXSEL_RESERVED && pop);
endmodule // uts_uart_tx_status_control

// ===== rtl/uts_pkg.sv
package uts_pkg;
  // ---------------------------------------------------------------
  // Register map (word addresses, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TX_DATA = 4'h1;
  localparam logic [3:0] ADDR_BAUD_DIV = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h5;
  // ---------------------------------------------------------------
  // Field positions of the status/control register
  // ---------------------------------------------------------------
  localparam int BIT_IRQ_SEL1 = 15;
  localparam int BIT_POL_INV = 14;
  localparam int BIT_IRQ_SEL0 = 13;
  localparam int BIT_BREAK = 11;
  localparam int BIT_TX_EN = 10;
  localparam int BIT_BUF_FULL = 9;
  localparam int BIT_SHIFT_EMPTY = 8;
  localparam int BIT_RX_SEL1 = 7;
  localparam int BIT_RX_SEL0 = 6;
  localparam int BIT_RX_IDLE = 4;
  localparam int BIT_IR_EN = 5;
  // Writable control bits; 15,14,13,11,10,7,6,5
  localparam logic [15:0] CTRL_WMASK = 16'hECE0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // Transmit interrupt select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] TXSEL_CHAR_IN = 2'h0;
  localparam logic [1:0] TXSEL_ALL_DONE = 2'h1;
  localparam logic [1:0] TXSEL_BUF_EMPTY = 2'h2;
  localparam logic [1:0] TXSEL_RESERVED = 2'h3;
  // ---------------------------------------------------------------
  // Sizes and counts
  // ---------------------------------------------------------------
  localparam int TX_DEPTH = 4;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] BREAK_BITS = 4'hC;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
  localparam logic [3:0] IR_PULSE_DIV = 4'h3;
  // Interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_BREAK_DONE = 1;
  localparam int IRQ_RX = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Transmitter states, Gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    UTS_IDLE = 2'b00,
    UTS_START = 2'b01,
    UTS_DATA = 2'b11,
    UTS_STOP = 2'b10
  } uts_state_t;
endpackage : uts_pkg

// ===== verif/uts_rx_model.sv
// Remote receiver on the transmit pin, 8N1 frames and sync breaks
module uts_rx_model (
  input wire logic clock_i,
  input wire logic line_i,
  input wire logic [15:0] div_i,
  output logic got_o,
  output logic [7:0] byte_o,
  output logic brk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] sh;
  // Mid-bit sampling; a stop at bit 8 ends a char, at bit 12 after zeros a break
  initial begin
    got_o = 1'b0;
    brk_o = 1'b0;
    byte_o = 8'h00;
    sh = 13'h0000;
    forever begin
      @(posedge clock_i);
      got_o <= 1'b0;
      brk_o <= 1'b0;
      if (line_i === 1'b0) begin
        repeat ((div_i + 1) / 2) @(posedge clock_i);
        for (int i = 0; i < 13; i++) begin
          repeat (div_i + 1) @(posedge clock_i);
          sh[i] = line_i;
          if (i == 8 && line_i === 1'b1) begin
            got_o <= 1'b1;
            byte_o <= sh[7:0];
            break;
          end
          if (i == 12) brk_o <= (line_i === 1'b1) && (sh[11:0] == 12'h000);
        end
      end
    end
  end
endmodule // uts_rx_model

// ===== verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [3:0] a; logic [15:0] d; logic [15:0] e;} uts_row_t;
  localparam logic [3:0] ST = uts_pkg::ADDR_STATUS_CONTROL;
  localparam logic [3:0] TXD = uts_pkg::ADDR_TX_DATA;
  localparam logic [3:0] BD = uts_pkg::ADDR_BAUD_DIV;
  localparam logic [3:0] IS = uts_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] IE = uts_pkg::ADDR_IRQ_ENABLE;
  localparam logic [3:0] IC = uts_pkg::ADDR_IRQ_CLEAR;
  logic clock_i, resetn_i, avs_read_i, avs_write_i, rx_char_i, avs_waitrequest_o, tx_line_o, tx_line_oe_o, irq_o;
  logic clk_en_i;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [2:0] rx_count_i;
  logic got, brk;
  logic [7:0] rbyte;
  logic [7:0] rxq[$];
  int err_total, n_tests, brk_cnt;
  // Released pin is pulled up, so the receiver sees idle then
  wire logic tx_pin = tx_line_oe_o ? tx_line_o : 1'b1;
  uts_row_t tbl[12] = '{
    '{1'b0, ST, 16'h0000, 16'h0110},
    '{1'b0, BD, 16'h0000, uts_pkg::BAUD_DIV_RESET},
    '{1'b0, IS, 16'h0000, 16'h0000},
    '{1'b0, 4'hF, 16'h0000, 16'h0000},
    '{1'b1, 4'hF, 16'hFFFF, 16'h0000},
    '{1'b0, 4'hF, 16'h0000, 16'h0000},
    '{1'b1, BD, 16'h0003, 16'h0000},
    '{1'b0, BD, 16'h0000, 16'h0003},
    '{1'b1, ST, 16'h04C0, 16'h0000},
    '{1'b0, ST, 16'h0000, 16'h05D0},
    '{1'b1, IC, 16'h0007, 16'h0000},
    '{1'b0, IS, 16'h0000, 16'h0000}};
  // Rx-side cases: control value, fill count, expected rx irq bit
  logic [15:0] rxt[5][3] = '{'{16'h04C0, 3, 0}, '{16'h04C0, 4, 4}, '{16'h0480, 3, 4}, '{16'h0400, 1, 4}, '{16'h0440, 1, 4}};
  uts_uart_tx_status_control u_uts_uart_tx_status_control (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_count_i(rx_count_i), .rx_char_i(rx_char_i),
    .tx_line_o(tx_line_o), .tx_line_oe_o(tx_line_oe_o), .irq_o(irq_o));
  uts_rx_model u_uts_rx_model (.clock_i(clock_i), .line_i(tx_pin), .div_i(16'h0003), .got_o(got), .byte_o(rbyte),
    .brk_o(brk));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Collect what the far end decoded
  always @(posedge clock_i) begin
    if (got) rxq.push_back(rbyte);
    if (brk) brk_cnt++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {16'h0000, d};
    // No cycle count assumed; a stuck slave is caught by the watchdog
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    check(q & m, e);
  endtask
  // Wait for the receiver to hold n chars; the watchdog bounds it
  task automatic wait_rx(input int n);
    while (rxq.size() < n) @(posedge clock_i);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cut a hang short, well past the expected run
  initial begin
    #(40000 * 5);
    err_total++;
    end_of_test();
  end
  initial begin
    {resetn_i, avs_read_i, avs_write_i, rx_char_i, avs_address_i, avs_writedata_i, rx_count_i} = '0;
    err_total = 0;
    n_tests = 0;
    brk_cnt = 0;
    clk_en_i = 1'b1;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (tbl[i]) if (tbl[i].wr) wr(tbl[i].a, tbl[i].d); else rd(tbl[i].a, tbl[i].e);
    check(16'({tx_line_oe_o, tx_line_o}), 16'h0003);
    // Six back to back: one to shifter, four buffered, the last refused
    for (int i = 0; i < 6; i++) wr(TXD, 16'(8'hA0 + 8'(i)));
    rd(ST, 16'h06D0);
    wait_rx(5);
    repeat (80) @(posedge clock_i);
    check(16'(rxq.size()), 16'h0005);
    for (int i = 0; i < 5; i++) check(16'(rxq[i]), 16'(8'hA0 + 8'(i)));
    rd(ST, 16'h05D0);
    rd(IS, 16'h0001, 16'h0001);
    // Enable lands on the take edge, so look one edge later
    wr(IE, 16'h0001);
    @(posedge clock_i);
    check(16'(irq_o), 16'h0001);
    wr(IE, 16'h0000);
    @(posedge clock_i);
    check(16'(irq_o), 16'h0000);
    wr(IC, 16'h0007);
    rd(IS, 16'h0000, 16'h0001);
    // Code 10: fires as soon as the char moves out of the buffer
    wr(ST, 16'h84C0);
    wr(TXD, 16'h005A);
    // Load waits for the next baud tick, well inside the frame
    repeat (5) @(posedge clock_i);
    rd(IS, 16'h0001, 16'h0001);
    wait_rx(6);
    wr(IC, 16'h0007);
    // Code 01: only once the last char has left the shifter
    wr(ST, 16'h24C0);
    wr(TXD, 16'h00C3);
    rd(IS, 16'h0000, 16'h0001);
    wait_rx(7);
    repeat (10) @(posedge clock_i);
    rd(IS, 16'h0001, 16'h0001);
    check(16'({rxq[5], rxq[6]}), 16'h5AC3);
    // Code 11: reserved, a full frame must raise nothing
    wr(IC, 16'h0007);
    wr(ST, 16'hA4C0);
    wr(TXD, 16'h0033);
    wait_rx(8);
    repeat (10) @(posedge clock_i);
    rd(IS, 16'h0000, 16'h0001);
    check(16'(rxq[7]), 16'h0033);
    wr(ST, 16'h0CC0);
    while (brk_cnt == 0) @(posedge clock_i);
    repeat (10) @(posedge clock_i);
    check(16'(brk_cnt), 16'h0001);
    rd(ST, 16'h05D0);
    rd(IS, 16'h0002, 16'h0002);
    foreach (rxt[i]) begin
      wr(ST, rxt[i][0]);
      wr(IC, 16'h0007);
      @(posedge clock_i);
      rx_char_i <= 1'b1;
      rx_count_i <= rxt[i][1][2:0];
      @(posedge clock_i);
      rx_char_i <= 1'b0;
      rd(IS, rxt[i][2], 16'h0004);
    end
    wr(ST, 16'h4400);
    repeat (3) @(posedge clock_i);
    check(16'(tx_line_o), 16'h0000);
    wr(ST, 16'h4420);
    repeat (3) @(posedge clock_i);
    check(16'(tx_line_o), 16'h0001);
    // Abort in mid-frame with chars still queued
    wr(ST, 16'h0400);
    for (int i = 0; i < 3; i++) wr(TXD, 16'h0055);
    wr(ST, 16'h0000);
    repeat (2) @(posedge clock_i);
    check(16'(tx_line_oe_o), 16'h0000);
    rd(ST, 16'h0110);
    wr(ST, 16'h0400);
    repeat (20) @(posedge clock_i);
    rd(ST, 16'h0510);
    // Clock enable low freezes a queued frame
    wr(TXD, 16'h000F);
    clk_en_i <= 1'b0;
    repeat (100) @(posedge clock_i);
    clk_en_i <= 1'b1;
    rd(ST, 16'h0410);
    end_of_test();
  end
endmodule // testbench
